// [logic/wwrs_defs.svh]
// Timing constants for the watchdog, wake and reset supervisor
`ifndef WWRS_DEFS_SVH
`define WWRS_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and timing base
// ----------------------------------------------------------------------
`define WWRS_CLK_PERIOD_NS   4
`define WWRS_TICK_NS         1000
`define WWRS_TICK_CYCLES     (`WWRS_TICK_NS / `WWRS_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Times in base ticks (one tick = 1 us) and counter widths in bits
// ----------------------------------------------------------------------
`define WWRS_WAKE_PERIOD_US  40000
`define WWRS_WAKE_HALF_US    (`WWRS_WAKE_PERIOD_US / 2)
`define WWRS_RESET_PULSE_US  5000
`define WWRS_WAKE_DELAY_US   20000

`define WWRS_CNT_W           16
`define WWRS_TICK_W          12

`endif

// [logic/wwrs_pkg.sv]
// Types shared by the watchdog, wake and reset supervisor
`default_nettype none

package wwrs_pkg;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'h1,
    ST_DELAY = 3'h2,
    ST_RUN   = 3'h4
  } wwrs_state_t;

  typedef struct packed {
    logic resetN;
    logic wake;
  } wwrs_pins_t;

endpackage : wwrs_pkg

`default_nettype wire

// [logic/wwrs_supervisor.sv]
// Watchdog, periodic wake and active-low reset supervisor
`timescale 1ns/1ps
`default_nettype none
`include "wwrs_defs.svh"

module wwrs_supervisor
  import wwrs_pkg::*;
#(
  parameter int unsigned WAKE_HALF_TICKS   = `WWRS_WAKE_HALF_US,
  parameter int unsigned RESET_PULSE_TICKS = `WWRS_RESET_PULSE_US,
  parameter int unsigned WAKE_DELAY_TICKS  = `WWRS_WAKE_DELAY_US
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Processor side
  input  wire logic       watchdogInput,
  // Regulator comparator
  input  wire logic       outputGood,
  // Pins toward the processor
  output var  wwrs_pins_t hostPins
);

  localparam int unsigned TICK_CYCLES  = `WWRS_TICK_CYCLES;
  localparam int unsigned PERIOD_TICKS = 2 * WAKE_HALF_TICKS;

  function automatic logic atLimit(input logic [`WWRS_CNT_W-1:0] cnt, input int unsigned lim);
    atLimit = (cnt == `WWRS_CNT_W'(lim - 1));
  endfunction : atLimit

  // ----------------------------------------------------------------------
  // Common timing base
  // ----------------------------------------------------------------------
  logic [`WWRS_TICK_W-1:0] tickCnt;
  wire  logic              tick;

  assign tick = (tickCnt == `WWRS_TICK_W'(TICK_CYCLES - 1));

  always_ff @(posedge ref_clk) begin
    if (rst || tick) begin
      tickCnt <= '0;
    end else begin
      tickCnt <= tickCnt + `WWRS_TICK_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog edge detect
  // ----------------------------------------------------------------------
  // Previous level resets low so a low input at start is not an edge
  logic      wdPrev;
  wire logic fallEdge;

  assign fallEdge = wdPrev & ~watchdogInput;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wdPrev <= 1'h0;
    end else begin
      wdPrev <= watchdogInput;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  wwrs_state_t             state;
  wwrs_state_t             next_state;
  logic [`WWRS_CNT_W-1:0]  phaseCnt;
  logic [`WWRS_CNT_W-1:0]  next_phaseCnt;
  logic [`WWRS_CNT_W-1:0]  wdCnt;
  logic [`WWRS_CNT_W-1:0]  next_wdCnt;
  logic                    next_wake;

  wire logic inRun     = (state == ST_RUN);
  wire logic runEdge   = inRun && fallEdge;
  wire logic halfDone  = inRun && tick && atLimit(phaseCnt, WAKE_HALF_TICKS);
  wire logic wdTimeout = inRun && tick && !fallEdge && atLimit(wdCnt, PERIOD_TICKS);
  wire logic holdDone  = (state == ST_HOLD) && tick && atLimit(phaseCnt, RESET_PULSE_TICKS);
  wire logic delayDone = (state == ST_DELAY) && tick && atLimit(phaseCnt, WAKE_DELAY_TICKS);

  always_comb begin
    next_state    = state;
    next_phaseCnt = tick ? phaseCnt + `WWRS_CNT_W'(1) : phaseCnt;
    next_wdCnt    = (inRun && tick) ? wdCnt + `WWRS_CNT_W'(1) : wdCnt;
    next_wake     = hostPins.wake;
    case (state)
      ST_HOLD: begin
        next_wake = 1'h0;
        if (holdDone) begin
          next_state    = ST_DELAY;
          next_phaseCnt = '0;
        end
      end
      ST_DELAY: begin
        next_wake = 1'h0;
        if (delayDone) begin
          next_state    = ST_RUN;
          next_phaseCnt = '0;
          next_wdCnt    = '0;
          next_wake     = 1'h1;
        end
      end
      ST_RUN: begin
        if (runEdge) begin
          // Restart the low half so the edge is seen as a wake fall
          next_wake     = 1'h0;
          next_phaseCnt = '0;
          next_wdCnt    = '0;
        end else if (wdTimeout) begin
          next_state    = ST_HOLD;
          next_phaseCnt = '0;
          next_wake     = 1'h0;
        end else if (halfDone) begin
          next_wake     = ~hostPins.wake;
          next_phaseCnt = '0;
        end
      end
      default: begin
        next_state    = ST_HOLD;
        next_phaseCnt = '0;
        next_wake     = 1'h0;
      end
    endcase
    // Output drop overrides everything and holds the count at zero
    if (!outputGood) begin
      next_state    = ST_HOLD;
      next_phaseCnt = '0;
      next_wake     = 1'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state    <= ST_HOLD;
      phaseCnt <= '0;
      wdCnt    <= '0;
      hostPins <= '{resetN: 1'h0, wake: 1'h0};
    end else begin
      state           <= next_state;
      phaseCnt        <= next_phaseCnt;
      wdCnt           <= next_wdCnt;
      hostPins.resetN <= (next_state != ST_HOLD);
      hostPins.wake   <= next_wake;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // Reset output
  // ----------------------------------------------------------------------
  power_hold_a: assert property ($rose(hostPins.resetN) |-> $past(outputGood))
    else $error("reset released without output good");

  drop_reset_a: assert property (!outputGood |=> !hostPins.resetN)
    else $error("reset not low after output drop");

  good_clear_a: assert property (!outputGood |=> state == ST_HOLD && phaseCnt == '0)
    else $error("hold count not cleared while output low");

  hold_low_a: assert property ((state == ST_HOLD) |-> !hostPins.resetN && !hostPins.wake)
    else $error("reset or wake high in hold");

  pulse_width_a: assert property ($rose(hostPins.resetN)
    |-> $past(phaseCnt) == `WWRS_CNT_W'(RESET_PULSE_TICKS - 1))
    else $error("reset pulse width wrong");

  // ----------------------------------------------------------------------
  // Watchdog window
  // ----------------------------------------------------------------------
  edge_wake_a: assert property ((runEdge && outputGood) |=> !hostPins.wake && phaseCnt == '0)
    else $error("watchdog edge did not drop wake");

  // The host lets its line rise again a few cycles after each answer
  rise_ignore_a: assert property (inRun && !wdPrev && watchdogInput && !halfDone && !wdTimeout && outputGood
    |=> hostPins.wake == $past(hostPins.wake))
    else $error("rising watchdog edge moved wake");

  wd_window_a: assert property (inRun |-> wdCnt < `WWRS_CNT_W'(PERIOD_TICKS))
    else $error("watchdog window overran");

  timeout_reset_a: assert property ((wdTimeout && outputGood) |=> !hostPins.resetN ##1 state == ST_HOLD)
    else $error("missing watchdog did not reset");

  // ----------------------------------------------------------------------
  // Wake generator
  // ----------------------------------------------------------------------
  delay_low_a: assert property ((state == ST_DELAY) |-> !hostPins.wake)
    else $error("wake high during delay");

  run_entry_a: assert property ((delayDone && outputGood) |=> inRun && hostPins.wake && hostPins.resetN)
    else $error("wake not raised on run entry");

  // A timeout on the same tick forces wake low instead of toggling it
  half_toggle_a: assert property (halfDone && !fallEdge && !wdTimeout && outputGood
    |=> hostPins.wake != $past(hostPins.wake))
    else $error("wake did not toggle at half period");

  // ----------------------------------------------------------------------
  // Scenario coverage
  // ----------------------------------------------------------------------
  run_entry_c: cover property (state == ST_DELAY ##1 state == ST_RUN);
  edge_seen_c: cover property (runEdge);
  timeout_c: cover property (wdTimeout);
  drop_c: cover property (inRun ##1 !outputGood);
  half_rise_c: cover property (halfDone && !hostPins.wake);

endmodule : wwrs_supervisor

`default_nettype wire

// [verification/wwrs_host_model.sv]
// Host processor model that answers each wake rise with a watchdog edge
`timescale 1ns/1ps
`default_nettype none
module wwrs_host_model (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Bench control and pins
  input  wire logic answer,
  input  wire logic wake,
  output var  logic watchdogInput
);
  logic       wakeSeen;
  logic [3:0] lowCnt;
  // Low held several cycles so the later rise is a separate, ignored edge
  always_ff @(posedge ref_clk) begin
    wakeSeen <= wake;
    if (rst) begin
      watchdogInput <= 1'h1;
      lowCnt        <= 4'h0;
    end else if (lowCnt != 4'h0) begin
      lowCnt        <= lowCnt - 4'h1;
      watchdogInput <= (lowCnt == 4'h1);
    end else if (answer && wake && !wakeSeen) begin
      watchdogInput <= 1'h0;
      lowCnt        <= 4'h8;
    end
  end
endmodule : wwrs_host_model
`default_nettype wire

// [verification/wwrs_supervisor_bench.sv]
// Self-checking bench for the watchdog, wake and reset supervisor
`timescale 1ns/1ps
`default_nettype none
`include "wwrs_defs.svh"
module wwrs_supervisor_bench;
  import wwrs_pkg::*;
  localparam int TK = `WWRS_TICK_CYCLES;
  logic       ref_clk, rst, outputGood, answer, watchdogInput;
  wwrs_pins_t hostPins;
  int         errCount, nCompared, cnt;
  wwrs_supervisor #(.WAKE_HALF_TICKS(4), .RESET_PULSE_TICKS(2), .WAKE_DELAY_TICKS(3)) uut (
    .ref_clk(ref_clk), .rst(rst), .watchdogInput(watchdogInput), .outputGood(outputGood), .hostPins(hostPins));
  wwrs_host_model host (
    .ref_clk(ref_clk), .rst(rst), .answer(answer), .wake(hostPins.wake), .watchdogInput(watchdogInput));
  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic wrapUp();
    $display("compared=%0d mismatches=%0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrapUp
  task automatic chk(input logic got, input logic exp);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chkRange(input int got, input int lo, input int hi);
    nCompared++;
    if (got < lo || got > hi) begin
      errCount++;
      $display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chkRange
  // Samples one step after the edge so the design's updates have landed
  task automatic waitPin(input logic isWake, input logic lvl, input int lim);
    logic pin;
    cnt = 0;
    pin = isWake ? hostPins.wake : hostPins.resetN;
    while (pin !== lvl && cnt < lim) begin
      @(posedge ref_clk);
      #1;
      cnt++;
      pin = isWake ? hostPins.wake : hostPins.resetN;
    end
    if (pin !== lvl) begin
      errCount++;
      $display("FAIL t=%0t got=%h exp=%h", $time, pin, lvl);
      wrapUp();
    end
  endtask : waitPin
  task automatic powerUp();
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    #1;
    chk(hostPins.resetN, 1'h0);
    waitPin(1'h0, 1'h1, 4 * TK);
    chkRange(cnt, TK, 3 * TK);
    chk(hostPins.wake, 1'h0);
    waitPin(1'h1, 1'h1, 5 * TK);
    chkRange(cnt, 2 * TK, 4 * TK);
    $display("done powerUp");
  endtask : powerUp
  task automatic served();
    for (int i = 0; i < 8; i++) begin
      waitPin(1'h1, 1'h1, 6 * TK);
      waitPin(1'h1, 1'h0, 12);
      chkRange(cnt, 1, 4);
      chk(hostPins.resetN, 1'h1);
    end
    $display("done served");
  endtask : served
  task automatic timeout();
    @(posedge ref_clk);
    answer <= 1'h0;
    waitPin(1'h1, 1'h1, 6 * TK);
    waitPin(1'h1, 1'h0, 6 * TK);
    chkRange(cnt, 3 * TK, 5 * TK);
    waitPin(1'h0, 1'h0, 2 * TK);
    chk(hostPins.wake, 1'h0);
    @(posedge ref_clk);
    answer <= 1'h1;
    waitPin(1'h0, 1'h1, 4 * TK);
    chkRange(cnt, TK, 3 * TK);
    $display("done timeout");
  endtask : timeout
  task automatic dropGood();
    waitPin(1'h1, 1'h1, 6 * TK);
    @(posedge ref_clk);
    outputGood <= 1'h0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(hostPins.resetN, 1'h0);
    chk(hostPins.wake, 1'h0);
    repeat (4 * TK) @(posedge ref_clk);
    #1;
    chk(hostPins.resetN, 1'h0);
    @(posedge ref_clk);
    outputGood <= 1'h1;
    waitPin(1'h0, 1'h1, 4 * TK);
    chkRange(cnt, TK, 3 * TK);
    $display("done dropGood");
  endtask : dropGood
  initial begin
    rst        = 1'h1;
    outputGood = 1'h1;
    answer     = 1'h1;
    errCount   = 0;
    nCompared  = 0;
    powerUp();
    served();
    timeout();
    dropGood();
    wrapUp();
  end
endmodule : wwrs_supervisor_bench
`default_nettype wire
